// file: mnm_defs.svh
`ifndef MNM_DEFS_SVH
`define MNM_DEFS_SVH

// Extended opcodes of the operations served
`define MNM_XO_MULHWU   10'd11
`define MNM_XO_MULLHWU  10'd392
`define MNM_XO_MULLW    10'd235
`define MNM_XO_NAND     10'd476
`define MNM_XO_NEG      10'd104
`define MNM_XO_NCHW     10'd174
`define MNM_XO_NCHWS    10'd238
`define MNM_XO_NHHW     10'd46
`define MNM_XO_NHHWS    10'd110
`define MNM_XO_NLHW     10'd430
`define MNM_XO_MULLHW   10'd424
// Condition field bit positions, msb first
`define MNM_CR_LT       3
`define MNM_CR_GT       2
`define MNM_CR_EQ       1
`define MNM_CR_SO       0
// Saturation limits
`define MNM_MAX_POS     32'h7fffffff
`define MNM_MAX_NEG     32'h80000000

`endif

// file: mnm_pkg.sv
package mnm_pkg;
  typedef enum logic [3:0] {
    MNM_OP_NONE,
    MNM_OP_MULHWU,
    MNM_OP_MULLHW,
    MNM_OP_MULLHWU,
    MNM_OP_MULLI,
    MNM_OP_MULLW,
    MNM_OP_NAND,
    MNM_OP_NEG,
    MNM_OP_NCHW,
    MNM_OP_NCHWS,
    MNM_OP_NHHW,
    MNM_OP_NHHWS,
    MNM_OP_NLHW
  } mnm_op_t;
  typedef enum logic [1:0] {
    MNM_ST_IDLE,
    MNM_ST_BUSY
  } mnm_state_t;
endpackage

// file: mnm_mult.sv
`timescale 1ns/100ps
module mnm_mult #(
  parameter int W = 32
) (
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           sgn,
  output logic      [2*W-1:0] prod
);
  logic signed [W:0]     a_x;
  logic signed [W:0]     b_x;
  logic signed [2*W+1:0] p_x;

  if (W < 2) begin : g_width_check
    $error("mnm_mult: width too small");
  end

  // One signed multiplier serves both signednesses by extending one bit
  always_comb begin
    a_x  = {sgn & a[W-1], a};
    b_x  = {sgn & b[W-1], b};
    p_x  = a_x * b_x;
    prod = p_x[2*W-1:0];
  end
endmodule

// file: mnm_cr_unit.sv
`timescale 1ns/100ps
`include "mnm_defs.svh"
module mnm_cr_unit (
  input  wire logic [31:0] result,
  input  wire logic        so,
  output logic      [3:0]  field
);
  // Signed compare against zero
  always_comb begin
    field                = 4'h0;
    field[`MNM_CR_LT]    = result[31];
    field[`MNM_CR_GT]    = ~result[31] & (result != 32'h0);
    field[`MNM_CR_EQ]    = (result == 32'h0);
    field[`MNM_CR_SO]    = so;
  end
endmodule

// file: mnm_exec.sv
`timescale 1ns/100ps
`include "mnm_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module mnm_exec (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 issue_valid,
  input  wire mnm_pkg::mnm_op_t     issue_op,
  input  wire logic                 overflow_enable,
  input  wire logic                 record_bit,
  input  wire logic [31:0]          source_a_gpr,
  input  wire logic [31:0]          source_b_gpr,
  input  wire logic [31:0]          source_s_gpr,
  input  wire logic [31:0]          target_gpr,
  input  wire logic [15:0]          immediate_field,
  input  wire logic                 summary_clear,
  output logic                      result_valid,
  output logic      [31:0]          result_data,
  output logic                      cr_write,
  output logic      [3:0]           condition_field_zero,
  output logic                      overflow_flag,
  output logic                      summary_overflow_flag
);
  import mnm_pkg::*;

  localparam int XLEN = 32;
  localparam int HALF = XLEN / 2;

  // Port widths are fixed at one word; this guards edits to the constants
  if (XLEN != 32 || HALF != 16) begin : g_width_check
    $error("mnm_exec: only a 32-bit word is served");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halfword operands, extended to a word
  logic [31:0] a_hi_s;
  logic [31:0] a_lo_s;
  logic [31:0] b_hi_s;
  logic [31:0] b_lo_s;
  logic [31:0] a_lo_u;
  logic [31:0] b_lo_u;
  logic [31:0] imm_s;

  assign a_hi_s = {{HALF{source_a_gpr[31]}}, source_a_gpr[31:16]};
  assign a_lo_s = {{HALF{source_a_gpr[15]}}, source_a_gpr[15:0]};
  assign b_hi_s = {{HALF{source_b_gpr[31]}}, source_b_gpr[31:16]};
  assign b_lo_s = {{HALF{source_b_gpr[15]}}, source_b_gpr[15:0]};
  // Zero-extended copies for the unsigned halfword form
  assign a_lo_u = {{HALF{1'b0}}, source_a_gpr[15:0]};
  assign b_lo_u = {{HALF{1'b0}}, source_b_gpr[15:0]};
  assign imm_s  = {{HALF{immediate_field[15]}}, immediate_field};

  //////////////////////////////////////////////////////////////////////////////
  // Operand selection
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  logic        mul_sgn;
  logic [63:0] mul_p;
  logic [31:0] res;
  logic        ovf;
  logic        acc_op;
  logic        sat_op;
  logic [31:0] nprod;
  logic [32:0] temp;
  logic [3:0]  cr_new;
  logic        so_now;

  // Halfword selection; bit 0 is the msb in the printed numbering
  always_comb begin
    mul_a   = source_a_gpr;
    mul_b   = source_b_gpr;
    mul_sgn = 1'b1;
    acc_op  = 1'b0;
    sat_op  = 1'b0;
    case (issue_op)
      MNM_OP_MULHWU: begin
        mul_sgn = 1'b0;
      end
      MNM_OP_MULLHW: begin
        mul_a = a_lo_s;
        mul_b = b_lo_s;
      end
      MNM_OP_MULLHWU: begin
        mul_a   = a_lo_u;
        mul_b   = b_lo_u;
        mul_sgn = 1'b0;
      end
      MNM_OP_MULLI: begin
        mul_b = imm_s;
      end
      MNM_OP_NCHW, MNM_OP_NCHWS: begin
        mul_a  = a_lo_s;
        mul_b  = b_hi_s;
        acc_op = 1'b1;
        sat_op = (issue_op == MNM_OP_NCHWS);
      end
      MNM_OP_NHHW, MNM_OP_NHHWS: begin
        mul_a  = a_hi_s;
        mul_b  = b_hi_s;
        acc_op = 1'b1;
        sat_op = (issue_op == MNM_OP_NHHWS);
      end
      MNM_OP_NLHW: begin
        mul_a  = a_lo_s;
        mul_b  = b_lo_s;
        acc_op = 1'b1;
      end
      default: begin
        mul_sgn = 1'b1;
      end
    endcase
  end

  mnm_mult #(
    .W    (32)
  ) u_mult (
    .a    (mul_a),
    .b    (mul_b),
    .sgn  (mul_sgn),
    .prod (mul_p)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Result and overflow
  logic [31:0] prod_hi;
  logic [31:0] prod_lo;
  logic [31:0] nand_w;
  logic [31:0] neg_w;
  logic [31:0] sat_val;
  logic [31:0] acc_sum;
  logic        acc_ovf;
  logic        mullw_ovf;
  logic        neg_ovf;

  // Low word of a product is the same for either signedness
  assign prod_hi = mul_p[63:32];
  assign prod_lo = mul_p[31:0];

  // One cell per bit keeps the logical path clear of the multiplier
  for (genvar gi = 0; gi < XLEN; gi++) begin : g_nand
    assign nand_w[gi] = ~(source_s_gpr[gi] & source_b_gpr[gi]);
  end

  assign neg_w = ~source_a_gpr + 32'h1;

  // Upper word must repeat the sign of the lower word
  assign mullw_ovf = (prod_hi != {32{prod_lo[31]}});
  // The most negative word has no positive twin
  assign neg_ovf = (source_a_gpr == `MNM_MAX_NEG);

  // Clamp toward the sign of the old accumulator
  always_comb begin
    sat_val = `MNM_MAX_POS;
    if (target_gpr[31]) begin
      sat_val = `MNM_MAX_NEG;
    end
  end

  // A 33-bit sum keeps the carry apart from the sign used for overflow
  always_comb begin
    nprod   = 32'h0 - prod_lo;
    temp    = {nprod[31], nprod} + {target_gpr[31], target_gpr};
    acc_sum = temp[31:0];
    // Like-signed addends whose sum changes sign
    acc_ovf = (nprod[31] == target_gpr[31]) && (target_gpr[31] != temp[31]);
    if (sat_op && acc_ovf) begin
      acc_sum = sat_val;
    end
  end

  // Plain multiplies other than the unsigned high-word form take the low product word
  always_comb begin
    res = prod_lo;
    ovf = 1'b0;
    case (issue_op)
      MNM_OP_MULHWU: begin
        res = prod_hi;
      end
      MNM_OP_MULLI: begin
        res = prod_lo;
      end
      MNM_OP_MULLW: begin
        res = prod_lo;
        ovf = mullw_ovf;
      end
      MNM_OP_NAND: begin
        res = nand_w;
      end
      MNM_OP_NEG: begin
        res = neg_w;
        ovf = neg_ovf;
      end
      default: begin
        if (acc_op) begin
          res = acc_sum;
          ovf = acc_ovf;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation classes
  logic is_any;
  logic is_mullw;
  logic is_neg;
  logic is_mulli;
  logic is_ovf_op;
  logic is_rec_op;
  logic flag_upd;

  always_comb begin
    is_any    = (issue_op != MNM_OP_NONE);
    is_mullw  = (issue_op == MNM_OP_MULLW);
    is_neg    = (issue_op == MNM_OP_NEG);
    is_mulli  = (issue_op == MNM_OP_MULLI);
    // Only these forms may touch the overflow flags
    is_ovf_op = acc_op | is_mullw | is_neg;
    // The immediate form carries no record bit
    is_rec_op = is_any & ~is_mulli;
    flag_upd  = issue_valid & overflow_enable & is_ovf_op;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overflow and summary flags
  logic ov_q;
  logic ov_d;
  logic so_q;
  logic so_d;

  // Set beats a same-cycle clear
  always_comb begin
    ov_d = ov_q;
    so_d = so_q;
    if (summary_clear) begin
      ov_d = 1'b0;
      so_d = 1'b0;
    end
    if (flag_upd) begin
      ov_d = ovf;
      if (ovf) begin
        so_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ov_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      ov_q <= ov_d;
      so_q <= so_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition field
  logic       cw_q;
  logic       cw_d;
  logic [3:0] cr_q;
  logic [3:0] cr_d;

  // Summary bit shows the flag as this result leaves it, clear included
  assign so_now = so_d;

  mnm_cr_unit u_cr (
    .result (res),
    .so     (so_now),
    .field  (cr_new)
  );

  always_comb begin
    cw_d = issue_valid & is_rec_op & record_bit;
    cr_d = cr_q;
    if (cw_d) begin
      cr_d = cr_new;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cw_q <= 1'b0;
      cr_q <= 4'h0;
    end else begin
      cw_q <= cw_d;
      cr_q <= cr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result word
  logic        rv_q;
  logic        rv_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  // Data holds between results; only the valid pulse marks a new one
  always_comb begin
    rv_d = issue_valid & is_any;
    rd_d = rd_q;
    if (rv_d) begin
      rd_d = res;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end

  assign result_valid          = rv_q;
  assign result_data           = rd_q;
  assign cr_write              = cw_q;
  assign condition_field_zero  = cr_q;
  assign overflow_flag         = ov_q;
  assign summary_overflow_flag = so_q;
endmodule

// file: mnm_exec_properties.sv
`timescale 1ns/100ps
module mnm_exec_properties (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             issue_valid,
  input wire mnm_pkg::mnm_op_t issue_op,
  input wire logic             overflow_enable,
  input wire logic             record_bit,
  input wire logic [31:0]      source_a_gpr,
  input wire logic [31:0]      source_b_gpr,
  input wire logic [31:0]      source_s_gpr,
  input wire logic             summary_clear,
  input wire logic             result_valid,
  input wire logic [31:0]      result_data,
  input wire logic             cr_write,
  input wire logic [3:0]       condition_field_zero,
  input wire logic             overflow_flag,
  input wire logic             summary_overflow_flag
);
  import mnm_pkg::*;
  logic signed [63:0] pw;
  logic               ovw;
  logic               go;
  assign pw = $signed(source_a_gpr) * $signed(source_b_gpr);
  assign ovw = pw[63:31] != {33{pw[31]}};
  assign go = issue_valid && issue_op != MNM_OP_NONE;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////
  AST_ANSWER: assert property (go |=> result_valid) else $error("no result after issue");
  AST_QUIET: assert property (!go |=> !result_valid) else $error("result without issue");
  AST_NAND: assert property (go && issue_op == MNM_OP_NAND |=>
    result_data == ~($past(source_s_gpr) & $past(source_b_gpr))) else $error("nand wrong");
  AST_NEG: assert property (go && issue_op == MNM_OP_NEG |=>
    result_data == ~$past(source_a_gpr) + 32'h1) else $error("negate wrong");
  AST_RECORD: assert property (go && record_bit && issue_op != MNM_OP_MULLI |=>
    cr_write) else $error("record missing");
  AST_CR_HOLD: assert property (!cr_write |-> $stable(condition_field_zero))
    else $error("condition field moved");
  AST_CR_CMP: assert property (cr_write |-> condition_field_zero == {result_data[31],
    !result_data[31] && result_data != 0, result_data == 0, summary_overflow_flag})
    else $error("condition bits wrong");
  AST_OV_SO: assert property (overflow_flag |-> summary_overflow_flag)
    else $error("overflow without summary");
  AST_SO_STICK: assert property ($past(summary_overflow_flag) && !$past(summary_clear)
    |-> summary_overflow_flag) else $error("summary lost");
  AST_MULLW_OV: assert property (go && issue_op == MNM_OP_MULLW && overflow_enable
    |=> overflow_flag == $past(ovw)) else $error("word overflow wrong");
  cover property (cr_write && condition_field_zero[3]);
  cover property (go && issue_op == MNM_OP_NCHWS);
  cover property ($rose(overflow_flag));
endmodule
bind mnm_exec mnm_exec_properties u_mnm_exec_properties (.*);

// file: mnm_dec_model.sv
`timescale 1ns/100ps
`include "mnm_defs.svh"
module mnm_dec_model (
  input  wire logic [9:0] xo,
  input  wire logic       imm_form,
  output mnm_pkg::mnm_op_t op
);
  import mnm_pkg::*;
  // Unknown codes decode to no operation
  always_comb begin
    if (imm_form) begin
      op = MNM_OP_MULLI;
    end else begin
      case (xo)
        `MNM_XO_MULHWU:  op = MNM_OP_MULHWU;
        `MNM_XO_MULLHW:  op = MNM_OP_MULLHW;
        `MNM_XO_MULLHWU: op = MNM_OP_MULLHWU;
        `MNM_XO_MULLW:   op = MNM_OP_MULLW;
        `MNM_XO_NAND:    op = MNM_OP_NAND;
        `MNM_XO_NEG:     op = MNM_OP_NEG;
        `MNM_XO_NCHW:    op = MNM_OP_NCHW;
        `MNM_XO_NCHWS:   op = MNM_OP_NCHWS;
        `MNM_XO_NHHW:    op = MNM_OP_NHHW;
        `MNM_XO_NHHWS:   op = MNM_OP_NHHWS;
        `MNM_XO_NLHW:    op = MNM_OP_NLHW;
        default:         op = MNM_OP_NONE;
      endcase
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/100ps
`include "mnm_defs.svh"
module tb;
  import mnm_pkg::*;
  logic        clk = 0, nrst = 0, iv = 0, oe = 0, rc = 0, clr = 0, imf = 0;
  logic [9:0]  xo = 0;
  logic [31:0] a = 0, b = 0, s = 0, t = 0, rd, e_rd = 0;
  logic [15:0] im = 0;
  logic [3:0]  cr, e_cr = 0;
  logic        rv, cw, ov, so, e_rv = 0, e_cw = 0, e_ov = 0, e_so = 0;
  mnm_op_t     op;
  int          fail_count = 0, check_count = 0, seed = 32'h924383f1, k;
  logic [9:0]  tab [12] = '{`MNM_XO_MULHWU, `MNM_XO_MULLHW, `MNM_XO_MULLHWU, `MNM_XO_MULLW,
    `MNM_XO_NAND, `MNM_XO_NEG, `MNM_XO_NCHW, `MNM_XO_NCHWS, `MNM_XO_NHHW, `MNM_XO_NHHWS,
    `MNM_XO_NLHW, 10'h3ff};
  always #5 clk = ~clk;
  mnm_dec_model u_mnm_dec_model (.xo(xo), .imm_form(imf), .op(op));
  mnm_exec u_mnm_exec (.clk(clk), .nrst(nrst), .issue_valid(iv), .issue_op(op),
    .overflow_enable(oe), .record_bit(rc), .source_a_gpr(a), .source_b_gpr(b),
    .source_s_gpr(s), .target_gpr(t), .immediate_field(im), .summary_clear(clr),
    .result_valid(rv), .result_data(rd), .cr_write(cw), .condition_field_zero(cr),
    .overflow_flag(ov), .summary_overflow_flag(so));
  ////////////////////////////////
  function automatic logic [32:0] calc(mnm_op_t o, logic [31:0] x, y, z, w, logic [15:0] m);
    logic signed [63:0] p;
    logic [31:0]        np, r;
    logic               v;
    case (o)
      MNM_OP_MULHWU:  p = {32'h0, x} * {32'h0, y};
      MNM_OP_MULLHW:  p = $signed(x[15:0]) * $signed(y[15:0]);
      MNM_OP_MULLHWU: p = x[15:0] * y[15:0];
      MNM_OP_MULLI:   p = $signed(x) * $signed(m);
      MNM_OP_NAND:    p = {32'h0, ~(w & y)};
      MNM_OP_NEG:     p = {32'h0, ~x + 32'h1};
      MNM_OP_NCHW, MNM_OP_NCHWS: p = $signed(x[15:0]) * $signed(y[31:16]);
      MNM_OP_NHHW, MNM_OP_NHHWS: p = $signed(x[31:16]) * $signed(y[31:16]);
      MNM_OP_NLHW:    p = $signed(x[15:0]) * $signed(y[15:0]);
      default:        p = $signed(x) * $signed(y);
    endcase
    r = (o == MNM_OP_MULHWU) ? p[63:32] : p[31:0];
    v = (o == MNM_OP_MULLW) ? p[63:31] != {33{p[31]}} : o == MNM_OP_NEG && x == 32'h80000000;
    if (o inside {MNM_OP_NCHW, MNM_OP_NCHWS, MNM_OP_NHHW, MNM_OP_NHHWS, MNM_OP_NLHW}) begin
      np = -p[31:0];
      r = np + z;
      v = np[31] == z[31] && z[31] != r[31];
      if (v && o inside {MNM_OP_NCHWS, MNM_OP_NHHWS}) r = z[31] ? 32'h80000000 : 32'h7fffffff;
    end
    return {v, r};
  endfunction
  task chk_data(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t result %h expected %h", $time, g, e);
    end
  endtask
  task chk_flags(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t flags %b expected %b", $time, g, e);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Checks last issue, then presents the next; runs every cycle so pulses are seen
  task step(input logic [9:0] xv, input logic fv, v, o_e, r_c, c_l,
            input logic [31:0] av, bv, tv, input logic [15:0] mv);
    logic [32:0] x;
    @(posedge clk);
    #1;
    chk_data(rd, e_rd);
    chk_flags({rv, cw, cr, ov, so}, {e_rv, e_cw, e_cr, e_ov, e_so});
    {xo, imf, iv, oe, rc, clr, a, b, t, im} = {xv, fv, v, o_e, r_c, c_l, av, bv, tv, mv};
    s = $random(seed);
    #1;
    x = calc(op, a, b, t, s, im);
    e_rv = v && op != MNM_OP_NONE;
    e_cw = e_rv && r_c && op != MNM_OP_MULLI;
    if (e_rv) e_rd = x[31:0];
    if (c_l) {e_ov, e_so} = 2'b00;
    if (e_rv && o_e && op inside {MNM_OP_MULLW, MNM_OP_NEG, MNM_OP_NCHW, MNM_OP_NCHWS,
        MNM_OP_NHHW, MNM_OP_NHHWS, MNM_OP_NLHW}) begin
      e_ov = x[32];
      e_so = e_so | x[32];
    end
    if (e_cw) e_cr = {e_rd[31], !e_rd[31] && e_rd != 0, e_rd == 0, e_so};
  endtask
  ////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1;
    step(`MNM_XO_NEG, 0, 1, 1, 1, 0, 32'h80000000, 0, 0, 0);
    step(`MNM_XO_MULLW, 0, 1, 1, 1, 0, 32'h00010000, 32'h00010000, 0, 0);
    step(`MNM_XO_MULLW, 0, 1, 1, 1, 1, 32'h3, 32'hfffffffb, 0, 0);
    step(`MNM_XO_NCHWS, 0, 1, 1, 1, 0, 32'h7fff, 32'h7fff0000, 32'h80000000, 0);
    step(`MNM_XO_NHHWS, 0, 1, 0, 1, 0, 32'h80000000, 32'h7fff0000, 32'h7fffffff, 0);
    step(`MNM_XO_NLHW, 0, 1, 1, 1, 1, 32'h7fff, 32'h7fff, 32'h80000000, 0);
    step(0, 1, 1, 0, 1, 0, 32'hfffffffe, 0, 0, 16'h8000);
    step(0, 0, 1, 1, 1, 0, 32'h5, 32'h5, 0, 0);
    repeat (3000) begin
      k = $unsigned($random(seed)) % 13;
      step(tab[k % 12], k == 12, $random(seed), $random(seed), $random(seed),
           ($random(seed) & 7) == 0, $random(seed), $random(seed), $random(seed), $random(seed));
    end
    step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    stop_test;
  end
  // About three times the expected run length
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
endmodule
